//--- core/dac_ctl_cfg.svh
// Register map, field positions, reset values and timing of the DAC write and load control
`ifndef DAC_CTL_CFG_SVH
`define DAC_CTL_CFG_SVH

`define FRAME_BITS          5'h10
`define CMD_DAC_WRITE_BIT   15
`define CMD_ADDR_HI         14
`define CMD_ADDR_LO         11
`define DAC_CH_HI           14
`define DAC_CH_LO           12
`define DAC_DATA_HI         11

`define ADDR_GEN_CTRL       4'h3
`define ADDR_DAC_PIN_SELECT 4'h5
`define ADDR_UPDATE_MODE    4'h7

`define DAC_RANGE_BIT       4
`define RST_DAC_RANGE       1'h0
`define RST_DAC_PIN_SELECT  8'h00
`define RST_UPDATE_MODE     2'h0
`define RST_DAC_CODE        12'h000

`define MODE_AUTO           2'h0
`define MODE_HOLD           2'h1
`define MODE_LOAD_ALL       2'h2

`define CLK_PERIOD_NS       100
`define LINK_PERIOD_NS      80

`endif

//--- core/dac_ctl_pkg.sv
// Types shared by the DAC write and load control
package dac_ctl_pkg;
    typedef logic [15:0] cmd_word_t;
    typedef logic [11:0] dac_code_t;
    typedef logic [2:0]  dac_ch_t;
    typedef logic [3:0]  reg_addr_t;
    typedef logic [1:0]  update_mode_t;
endpackage

//--- core/dac_write_load_ctrl.sv
// Serial command capture, DAC pin select, input/DAC registers and output update mode
//
// How it works
// [RULE1] Range bit: 0 gives 0..Vref, 1 gives 0..2Vref
// [RULE2] Host writes zeros to control bits 3..0
// [RULE3] Pin becomes DAC output after select bit set
// [RULE4] Frame with bit 15 set is DAC write
// [RULE5] Bits 14..12 channel, bits 11..0 data
// [RULE6] DAC write always lands in input register
// [RULE7] Mode 00 copies new input to DAC register
// [RULE8] Mode 01 keeps DAC registers unchanged
// [RULE9] Writing mode 10 loads all DAC registers together
// [RULE10] After load, mode returns to 01 if it was
// [RULE11] Pin select frame: bit15 0, address 0101
// [RULE12] Each low-byte select bit enables its DAC pin
// [RULE13] Select bit 0 leaves pin to other config
// [RULE14] Sixteen bits MSB first per frame, then act
`timescale 1ns/100ps
`default_nettype none
`include "dac_ctl_cfg.svh"

module dac_write_load_ctrl
    import dac_ctl_pkg::*;
#(
    parameter int CHANNELS = 8
)(
    input  wire logic                 i_clk,                // System clock, 10 MHz
    input  wire logic                 i_arst_n,             // Async reset, active low
    input  wire logic                 i_sclk,               // Serial link clock
    input  wire logic                 i_sync_n,             // Frame select, active low
    input  wire logic                 i_sdi,                // Serial data in
    output logic                      o_dac_range,          // 1: double span
    output logic [CHANNELS-1:0]       o_dac_pin_select_bits, // Pins acting as DAC outputs
    output logic [1:0]                o_output_update_mode, // Current update mode
    output logic [CHANNELS*12-1:0]    o_dac_code,           // DAC registers, ch0 in low bits
    output logic                      o_dac_update          // Pulse when DAC registers load
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_ff1;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_ff1 <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_ff1 <= 1'b1;
            rst_n   <= rst_ff1;
        end
    end

    // ------------------------------------------------------------
    // Link domain: frame capture
    // ------------------------------------------------------------
    logic       frame_idle;
    logic [4:0] bit_cnt;
    cmd_word_t  shift;
    cmd_word_t  word;
    logic       word_tgl;

    // Counter is cleared by the frame's own select, so no edge after the frame is needed
    assign frame_idle = i_sync_n | ~i_arst_n;

    always_ff @(negedge i_sclk or posedge frame_idle)
    begin
        if (frame_idle)
            bit_cnt <= 5'h00;
        else if (bit_cnt != `FRAME_BITS)
            bit_cnt <= bit_cnt + 5'h01;
    end

    always_ff @(negedge i_sclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            shift    <= 16'h0000;
            word     <= 16'h0000;
            word_tgl <= 1'b0;
        end
        else if (!i_sync_n && bit_cnt != `FRAME_BITS)
        begin
            shift <= {shift[14:0], i_sdi};                           // [RULE14]
            if (bit_cnt == `FRAME_BITS - 5'h01)
            begin
                // Word held until the next full frame, long after the crossing settles
                word     <= {shift[14:0], i_sdi};                    // [RULE14]
                word_tgl <= ~word_tgl;
            end
        end
    end

    // ------------------------------------------------------------
    // Crossing into the system clock
    // ------------------------------------------------------------
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic cmd_valid;

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end
        else
        begin
            tgl_s1 <= word_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    assign cmd_valid = tgl_s2 ^ tgl_s3;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic is_ctrl(input cmd_word_t w, input reg_addr_t a);
        return !w[`CMD_DAC_WRITE_BIT] && w[`CMD_ADDR_HI:`CMD_ADDR_LO] == a;
    endfunction

    logic      dac_wr;
    logic      pin_wr;
    logic      gen_wr;
    logic      mode_wr;
    dac_ch_t   wr_ch;
    dac_code_t wr_data;

    assign dac_wr  = cmd_valid && word[`CMD_DAC_WRITE_BIT];                  // [RULE4]
    assign pin_wr  = cmd_valid && is_ctrl(word, `ADDR_DAC_PIN_SELECT);       // [RULE11]
    assign gen_wr  = cmd_valid && is_ctrl(word, `ADDR_GEN_CTRL);
    assign mode_wr = cmd_valid && is_ctrl(word, `ADDR_UPDATE_MODE);
    assign wr_ch   = word[`DAC_CH_HI:`DAC_CH_LO];                            // [RULE5]
    assign wr_data = word[`DAC_DATA_HI:0];                                   // [RULE5]

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_dac_range <= `RST_DAC_RANGE;
        else if (gen_wr)
            o_dac_range <= word[`DAC_RANGE_BIT];                             // [RULE1]
    end

    // Bits 7..0 of the control word, bits 3..0 included, load the pin select bits
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_dac_pin_select_bits <= CHANNELS'(`RST_DAC_PIN_SELECT);         // [RULE13]
        else if (pin_wr)
            o_dac_pin_select_bits <= word[CHANNELS-1:0];                     // [RULE3] [RULE12]
    end

    // ------------------------------------------------------------
    // Input registers, DAC registers and update mode
    // ------------------------------------------------------------
    logic [CHANNELS*12-1:0] input_flat;
    logic                   load_all;

    // Mode 11 is reserved and leaves everything alone
    assign load_all = mode_wr && word[1:0] == `MODE_LOAD_ALL;                // [RULE9]

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            input_flat <= {CHANNELS{`RST_DAC_CODE}};
        else if (dac_wr)
            input_flat[wr_ch*12 +: 12] <= wr_data;                           // [RULE6]
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            o_output_update_mode <= `RST_UPDATE_MODE;
        else if (mode_wr && (word[1:0] == `MODE_AUTO || word[1:0] == `MODE_HOLD))
            o_output_update_mode <= word[1:0];
        // Load-all leaves the mode as it was, so a hold setting comes back  [RULE10]
    end

    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            o_dac_code   <= {CHANNELS{`RST_DAC_CODE}};
            o_dac_update <= 1'b0;
        end
        else
        begin
            o_dac_update <= 1'b0;
            if (load_all)
            begin
                o_dac_code   <= input_flat;                                  // [RULE9]
                o_dac_update <= 1'b1;
            end
            else if (dac_wr && o_output_update_mode == `MODE_AUTO)
            begin
                o_dac_code[wr_ch*12 +: 12] <= wr_data;                       // [RULE7]
                o_dac_update               <= 1'b1;
            end
            // Hold mode: DAC registers untouched by data writes  [RULE8]
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);

    property p_range_follows;
        gen_wr |=> o_dac_range == $past(word[`DAC_RANGE_BIT]);
    endproperty
    a_range_follows: assert property (p_range_follows) // [RULE1]
        else $error("range bit not taken from control write");

    property p_pin_select;
        pin_wr |=> o_dac_pin_select_bits == $past(word[CHANNELS-1:0]);
    endproperty
    a_pin_select: assert property (p_pin_select) // [RULE12]
        else $error("pin select not loaded");

    property p_pin_hold;
        !pin_wr |=> $stable(o_dac_pin_select_bits);
    endproperty
    a_pin_hold: assert property (p_pin_hold) // [RULE13]
        else $error("pin select changed without write");

    property p_dac_frame_no_ctrl;
        dac_wr |=> $stable(o_dac_pin_select_bits) && $stable(o_dac_range);
    endproperty
    a_dac_frame_no_ctrl: assert property (p_dac_frame_no_ctrl) // [RULE4]
        else $error("DAC write frame touched a control register");

    property p_input_store;
        dac_wr |=> input_flat[$past(wr_ch)*12 +: 12] == $past(wr_data);
    endproperty
    a_input_store: assert property (p_input_store) // [RULE6]
        else $error("input register not written");

    property p_auto_update;
        dac_wr && o_output_update_mode == `MODE_AUTO
            |=> o_dac_update && o_dac_code[$past(wr_ch)*12 +: 12] == $past(wr_data);
    endproperty
    a_auto_update: assert property (p_auto_update) // [RULE7]
        else $error("auto mode did not update DAC register");

    property p_hold_mode;
        dac_wr && o_output_update_mode == `MODE_HOLD |=> $stable(o_dac_code) && !o_dac_update;
    endproperty
    a_hold_mode: assert property (p_hold_mode) // [RULE8]
        else $error("hold mode changed a DAC register");

    property p_load_all;
        load_all |=> o_dac_code == $past(input_flat) && o_dac_update;
    endproperty
    a_load_all: assert property (p_load_all) // [RULE9]
        else $error("load-all did not copy input registers");

    property p_revert;
        load_all && o_output_update_mode == `MODE_HOLD |=> o_output_update_mode == `MODE_HOLD;
    endproperty
    a_revert: assert property (p_revert) // [RULE10]
        else $error("mode did not return to hold");

    property p_frame_done;
        @(negedge i_sclk) disable iff (i_sync_n)
        bit_cnt == `FRAME_BITS - 5'h01 |=> word_tgl != $past(word_tgl);
    endproperty
    a_frame_done: assert property (p_frame_done) // [RULE14]
        else $error("sixteenth bit did not complete the word");

    // Nothing moves without its own command
    property p_range_hold;
        !gen_wr |=> $stable(o_dac_range);
    endproperty
    a_range_hold: assert property (p_range_hold) // [RULE1]
        else $error("range bit changed without write");

    property p_input_hold;
        !dac_wr |=> $stable(input_flat);
    endproperty
    a_input_hold: assert property (p_input_hold) // [RULE6]
        else $error("input register changed without data write");

    property p_code_hold;
        !dac_wr && !load_all |=> $stable(o_dac_code) && !o_dac_update;
    endproperty
    a_code_hold: assert property (p_code_hold) // [RULE8]
        else $error("DAC register changed without a load");

    property p_mode_set;
        mode_wr && (word[1:0] == `MODE_AUTO || word[1:0] == `MODE_HOLD)
            |=> o_output_update_mode == $past(word[1:0]);
    endproperty
    a_mode_set: assert property (p_mode_set) // [RULE7]
        else $error("update mode not taken from write");

    property p_mode_hold;
        !mode_wr |=> $stable(o_output_update_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) // [RULE8]
        else $error("update mode changed without write");

    property p_load_keeps_mode;
        load_all |=> $stable(o_output_update_mode);
    endproperty
    a_load_keeps_mode: assert property (p_load_keeps_mode) // [RULE10]
        else $error("load-all did not restore the previous mode");

    // A word acted on twice would load a DAC register twice
    property p_cmd_once;
        cmd_valid |=> !cmd_valid;
    endproperty
    a_cmd_once: assert property (p_cmd_once) // [RULE14]
        else $error("command word acted on twice");

    property p_update_pulse;
        o_dac_update |=> !o_dac_update;
    endproperty
    a_update_pulse: assert property (p_update_pulse) // [RULE9]
        else $error("update pulse longer than one cycle");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_auto_write: cover property (dac_wr && o_output_update_mode == `MODE_AUTO);
    c_hold_then_load: cover property (dac_wr && o_output_update_mode == `MODE_HOLD
                                      ##[1:200] load_all);
    c_pin_select: cover property (pin_wr && word[7:0] == 8'hff);
    c_range_double: cover property (gen_wr && word[`DAC_RANGE_BIT]);
    c_load_in_auto: cover property (load_all && o_output_update_mode == `MODE_AUTO);

endmodule

`default_nettype wire

//--- test/spi_host_model.sv
// Host model that sends 16-bit command frames over the serial link
`timescale 1ns/100ps
`default_nettype none

module spi_host_model
    import dac_ctl_pkg::*;
(
    output logic o_sclk,   // Link clock, still between frames
    output logic o_sync_n, // Frame select, active low
    output logic o_sdi     // Serial data, MSB first
);
    localparam int HALF = 40;

    initial
    begin
        o_sclk   = 1'b1;
        o_sync_n = 1'b1;
        o_sdi    = 1'b0;
    end

    // ----------------------------------------
    // Frame sender
    // ----------------------------------------
    // Fewer than 16 bits gives an aborted frame, more adds trailing zeros
    task automatic send(input cmd_word_t w, input int nbits);
        #13;
        o_sync_n = 1'b0;
        for (int i = 15; i > 15 - nbits; i--)
        begin
            o_sdi = (i >= 0) ? w[i] : 1'b0;
            #HALF o_sclk = 1'b0;
            #HALF o_sclk = 1'b1;
        end
        #HALF o_sync_n = 1'b1;
        // Released line must not keep showing the last bit
        o_sdi = ~o_sdi;
        #(2*HALF);
    endtask
endmodule

`default_nettype wire

//--- test/tb_top.sv
// Self-checking bench for the DAC write and load control
`timescale 1ns/100ps
`default_nettype none

module tb_top
    import dac_ctl_pkg::*;
;

    logic        clk;
    logic        arst_n;
    logic        sclk;
    logic        sync_n;
    logic        sdi;
    logic        range_bit;
    logic        upd;
    logic [7:0]  sel;
    logic [1:0]  mode;
    logic [95:0] codes;
    int          n_errors;
    int          tests_run;
    int          n_upd;
    int          n;

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    dac_write_load_ctrl #(.CHANNELS(8)) dut (
        .i_clk                 (clk),
        .i_arst_n              (arst_n),
        .i_sclk                (sclk),
        .i_sync_n              (sync_n),
        .i_sdi                 (sdi),
        .o_dac_range           (range_bit),
        .o_dac_pin_select_bits (sel),
        .o_output_update_mode  (mode),
        .o_dac_code            (codes),
        .o_dac_update          (upd)
    );

    spi_host_model host (
        .o_sclk   (sclk),
        .o_sync_n (sync_n),
        .o_sdi    (sdi)
    );

    // Sampled away from the edge that launches the pulse
    always @(negedge clk)
    begin
        if (upd === 1'b1)
            n_upd++;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Eight cycles covers the 2 to 3 cycle crossing
    task automatic cmd(input cmd_word_t w);
        host.send(w, 16);
        repeat (8) @(negedge clk);
    endtask

    task automatic final_report;
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        n_errors  = 0;
        tests_run = 0;
        n_upd     = 0;
        arst_n    = 1'b0;
        // Reset acts at once; the internal copy is released two edges later
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        check("range", range_bit, 96'h0);
        check("select", sel, 96'h0);
        check("mode", mode, 96'h0);
        check("codes", codes, 96'h0);
        for (int c = 0; c < 8; c++)
        begin
            n = n_upd;
            cmd({1'b1, 3'(c), 12'h5a0 + 12'(c)});
            check("code", codes[12*c+:12], 12'h5a0 + 12'(c));
            check("update", n_upd, n + 1);
        end
        host.send(16'h1810, 8);
        repeat (8) @(negedge clk);
        check("short", range_bit, 96'h0);
        cmd(16'h1810);
        check("range", range_bit, 96'h1);
        cmd(16'h1800);
        check("range", range_bit, 96'h0);
        // A seventeenth bit must not shift the word
        host.send(16'h1810, 17);
        repeat (8) @(negedge clk);
        check("long", range_bit, 96'h1);
        cmd(16'h28ff);
        check("select", sel, 96'hff);
        cmd(16'h2805);
        check("select", sel, 96'h05);
        cmd(16'ha8ff);
        check("select", sel, 96'h05);
        check("code2", codes[35:24], 96'h8ff);
        cmd(16'h3801);
        check("mode", mode, 96'h1);
        n = n_upd;
        cmd(16'h9123);
        cmd(16'hf456);
        check("code1", codes[23:12], 96'h5a1);
        check("code7", codes[95:84], 96'h5a7);
        check("update", n_upd, n);
        cmd(16'h3802);
        check("code1", codes[23:12], 96'h123);
        check("code7", codes[95:84], 96'h456);
        check("update", n_upd, n + 1);
        check("mode", mode, 96'h1);
        cmd(16'h3800);
        cmd(16'h8abc);
        check("code0", codes[11:0], 96'habc);
        // Load-all from auto mode pulses once and keeps auto mode
        n = n_upd;
        cmd(16'h3802);
        check("update", n_upd, n + 1);
        check("mode", mode, 96'h0);
        cmd(16'h3803);
        check("mode", mode, 96'h0);
        // An address outside this block must not reach the range bit
        cmd(16'h0800);
        check("range", range_bit, 96'h1);
        final_report();
    end

    // Whole run is near 53 us; far beyond that means a hang
    initial
    begin
        #400000;
        n_errors++;
        final_report();
    end
endmodule

`default_nettype wire
